// *** byte_transfer_execution_tb.sv ***
// self-checking bench for the byte transfer executor
`timescale 1ns/1ns
module byte_transfer_execution_tb;
	import xfer_pkg::*;
	// executor and memory model nets
	logic        clk_in = 1'b0;
	logic        rst_in, ce_in, mem_we_out, mem_re_out, retire_out, illegal_out, chk_ok_out;
	logic [2:0]  chk_kind_in, chk_bit_out;
	logic [7:0]  prog_data_in, mem_wdata_out, mem_rdata_in, psw_out, chk_disp_in;
	logic [15:0] prog_addr_out, mem_addr_out, word_acc_out, chk_value_in, chk_offset_out;
	// tallies
	int          err_count = 0;
	int          n_compared = 0;
	// program run by the scenarios, in order
	logic [7:0]  prg [0:45] = '{
		OP_R_IMM, 8'h01, 8'h5A, OP_R_IMM, 8'h00, 8'h3C, OP_XCH_A_X, OP_R_IMM, 8'h07, 8'h12,
		OP_R_IMM, 8'h06, 8'h34, OP_PTR_OFS_A, 8'h05, OP_R_IMM, 8'h01, 8'h77, OP_XCH_PTR_OFS, 8'h05,
		OP_A_PTR_OFS, 8'h06, OP_XCH_A_R, 8'h02, OP_A_R, 8'h02, OP_A_R, 8'h01, OP_XCH_A_R, 8'h00,
		OP_PSW_IMM, 8'h51, 8'h51, OP_PSW_A, 8'h00, OP_ABS_A, 8'h01, 8'h80, OP_SHORT_IMM, 8'h10,
		8'hAA, OP_A_SHORT, 8'h10, OP_A_ABS, 8'h01, 8'h80};

	always #5 clk_in = ~clk_in;

	xfer_exec i_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .prog_addr_out(prog_addr_out),
		.prog_data_in(prog_data_in), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
		.mem_we_out(mem_we_out), .mem_re_out(mem_re_out), .mem_rdata_in(mem_rdata_in),
		.retire_out(retire_out), .illegal_out(illegal_out), .psw_out(psw_out), .word_acc_out(word_acc_out),
		.chk_kind_in(chk_kind_in), .chk_value_in(chk_value_in), .chk_disp_in(chk_disp_in),
		.chk_ok_out(chk_ok_out), .chk_bit_out(chk_bit_out), .chk_offset_out(chk_offset_out));
	xfer_mem_model i_mem (.clk_in(clk_in), .prog_addr_in(prog_addr_out), .prog_data_out(prog_data_in),
		.mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out), .mem_we_in(mem_we_out),
		.mem_re_in(mem_re_out), .mem_rdata_out(mem_rdata_in));

	// verdict and end of run
	task automatic wrap_up();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// the one comparison; callers zero-extend, except the sign-extended displacement
	task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one instruction: clocks to retire, next fetch address, refusal pulse
	task automatic step(input logic [15:0] nxt, input int clocks, input logic ill);
		int   n;
		logic seen;
		n = 0;
		seen = 1'b0;
		do
		begin
			@(negedge clk_in);
			n++;
			seen = seen | (illegal_out === 1'b1);
		end
		while (retire_out !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			err_count++;
			wrap_up();
		end
		cmp16(16'(n), 16'(clocks));
		cmp16(prog_addr_out, nxt);
		cmp16({15'h0, seen}, {15'h0, ill});
		// let the commit edge land
		@(posedge clk_in);
		#1;
	endtask

	// immediate loads, one-byte swap; first count starts mid clock 0
	task automatic run_moves();
		step(16'h0003, 5, 1'b0);
		step(16'h0006, 6, 1'b0);
		step(16'h0007, 4, 1'b0);
		cmp16(word_acc_out, 16'h3C5A);
		step(16'h000A, 6, 1'b0);
		step(16'h000D, 6, 1'b0);
	endtask

	// pointer plus offset store, swap and load
	task automatic run_pointer();
		step(16'h000F, 6, 1'b0);
		cmp16({8'h00, i_mem.data[16'h1239]}, 16'h003C);
		cmp16({8'h00, psw_out}, 16'h0000);
		step(16'h0012, 6, 1'b0);
		step(16'h0014, 8, 1'b0);
		cmp16({8'h00, i_mem.data[16'h1239]}, 16'h0077);
		cmp16(word_acc_out, 16'h3C5A);
		step(16'h0016, 6, 1'b0);
		cmp16(word_acc_out, 16'hC55A);
	endtask

	// register exchange and moves, then the refused operand forms
	task automatic run_refusals();
		step(16'h0018, 6, 1'b0);
		cmp16(word_acc_out, 16'h005A);
		step(16'h001A, 4, 1'b0);
		cmp16(word_acc_out, 16'hC55A);
		step(16'h001C, 4, 1'b1);
		step(16'h001E, 6, 1'b1);
		cmp16(word_acc_out, 16'hC55A);
	endtask

	// status word loads write every flag
	task automatic run_status();
		step(16'h0021, 6, 1'b0);
		cmp16({8'h00, psw_out}, 16'h0051);
		step(16'h0023, 4, 1'b0);
		cmp16({8'h00, psw_out}, 16'h00C5);
	endtask

	// absolute and short-direct transfers
	task automatic run_direct();
		step(16'h0026, 8, 1'b0);
		cmp16({8'h00, i_mem.data[16'h8001]}, 16'h00C5);
		step(16'h0029, 6, 1'b0);
		cmp16({8'h00, i_mem.data[16'hFE30]}, 16'h00AA);
		step(16'h002B, 4, 1'b0);
		cmp16(word_acc_out, 16'hAA5A);
		step(16'h002E, 8, 1'b0);
		cmp16(word_acc_out, 16'hC55A);
	endtask

	// one operand check, judged a clock later
	task automatic chk(input logic [2:0] kind, input logic [15:0] val, input logic [7:0] disp, input logic ok);
		@(negedge clk_in);
		chk_kind_in = kind;
		chk_value_in = val;
		chk_disp_in = disp;
		@(posedge clk_in);
		#1;
		cmp16({15'h0, chk_ok_out}, {15'h0, ok});
		cmp16({13'h0, chk_bit_out}, {13'h0, val[2:0]});
		cmp16(chk_offset_out, {{8{disp[7]}}, disp});
	endtask

	// window edges and alignment of every operand kind
	task automatic run_operands();
		chk(CHK_SHORT, 16'hFE20, 8'h80, 1'b1);
		chk(CHK_SHORT, 16'hFF1F, 8'h7F, 1'b1);
		chk(CHK_SHORT, 16'hFE1F, 8'hFF, 1'b0);
		chk(CHK_SHORT, 16'hFF20, 8'h00, 1'b0);
		chk(CHK_SHORT_PAIR, 16'hFE21, 8'h01, 1'b0);
		chk(CHK_SHORT_PAIR, 16'hFF1E, 8'h81, 1'b1);
		chk(CHK_ABS_BYTE, 16'hFFFF, 8'h05, 1'b1);
		chk(CHK_ABS_WORD, 16'h0001, 8'h06, 1'b0);
		chk(CHK_ABS_WORD, 16'hFFFE, 8'hFE, 1'b1);
		chk(CHK_CALLT, 16'h0040, 8'h02, 1'b1);
		chk(CHK_CALLT, 16'h007E, 8'h03, 1'b1);
		chk(CHK_CALLT, 16'h0041, 8'h04, 1'b0);
		chk(CHK_CALLT, 16'h0080, 8'h08, 1'b0);
		chk(CHK_CALLT, 16'h003E, 8'hC0, 1'b0);
	endtask

	// reset, program load, then the scenarios in program order
	initial
	begin
		rst_in = 1'b1;
		ce_in = 1'b1;
		chk_kind_in = 3'h0;
		chk_value_in = 16'h0000;
		chk_disp_in = 8'h00;
		for (int i = 0; i < 65536; i++)
			i_mem.prog[i] = (i < 46) ? prg[i] : 8'h00;
		i_mem.data[16'h123A] = 8'hC5;
		repeat (8) @(negedge clk_in);
		cmp16(prog_addr_out, PC_RESET);
		cmp16({8'h00, psw_out}, {8'h00, PSW_RESET});
		cmp16(word_acc_out, 16'h0000);
		rst_in = 1'b0;
		run_moves();
		run_pointer();
		run_refusals();
		run_status();
		run_direct();
		run_operands();
		wrap_up();
	end
endmodule

// *** core_if.sv ***
// link between the executor, its decoder and its register file
`timescale 1ns/1ns
interface core_if;
	import xfer_pkg::*;

	logic [7:0]  opcode;     // opcode being decoded
	logic [1:0]  len;        // instruction bytes
	logic [3:0]  clocks;     // instruction clocks
	exec_e       ex;         // execution class
	asrc_e       asrc;       // address source
	logic [2:0]  rd_sel;     // byte register read select
	logic [7:0]  rd_data;    // selected byte register
	logic [7:0]  a_data;     // accumulator
	logic [1:0]  pair_sel;   // pointer pair select
	logic [15:0] pair_data;  // selected pair
	logic [15:0] wacc_data;  // word accumulator
	logic        wr_en;      // byte register write
	logic [2:0]  wr_sel;     // byte register write select
	logic [7:0]  wr_data;    // byte register write data
	logic        a_wr_en;    // accumulator write
	logic [7:0]  a_wr_data;  // accumulator write data

	modport dec (input opcode, output len, output clocks, output ex, output asrc);
	modport rf (input rd_sel, input pair_sel, input wr_en, input wr_sel, input wr_data,
		input a_wr_en, input a_wr_data, output rd_data, output a_data, output pair_data,
		output wacc_data);
	modport exe (output opcode, input len, input clocks, input ex, input asrc,
		output rd_sel, output pair_sel, output wr_en, output wr_sel, output wr_data,
		output a_wr_en, output a_wr_data, input rd_data, input a_data, input pair_data,
		input wacc_data);
endinterface

// *** xfer_decode.sv ***
// opcode decoder: length, clock count, class and address source
`timescale 1ns/1ns
module xfer_decode
	import xfer_pkg::*;
(
	// decode link
	core_if.dec dif
);

	// one table row: bytes, clocks, class, address source
	function automatic logic [12:0] row(input logic [1:0] l, input logic [3:0] c,
		input exec_e e, input asrc_e s);
		row = {l, c, e, s};
	endfunction

	logic [12:0] r; // packed decode row

	// unknown opcodes run as one byte, four clocks, flagged illegal
	always_comb
	begin
		case (dif.opcode)
			OP_R_IMM:       r = row(2'h3, 4'h6, EX_R_IMM, AS_NONE);
			OP_SHORT_IMM:   r = row(2'h3, 4'h6, EX_MEM_IMM, AS_SHORT);
			OP_SFR_IMM:     r = row(2'h3, 4'h6, EX_MEM_IMM, AS_SFR);
			OP_A_R:         r = row(2'h2, 4'h4, EX_A_R, AS_NONE);
			OP_R_A:         r = row(2'h2, 4'h4, EX_R_A, AS_NONE);
			OP_A_SHORT:     r = row(2'h2, 4'h4, EX_LD_A, AS_SHORT);
			OP_SHORT_A:     r = row(2'h2, 4'h4, EX_ST_A, AS_SHORT);
			OP_A_SFR:       r = row(2'h2, 4'h4, EX_LD_A, AS_SFR);
			OP_SFR_A:       r = row(2'h2, 4'h4, EX_ST_A, AS_SFR);
			OP_A_ABS:       r = row(2'h3, 4'h8, EX_LD_A, AS_ABS);
			OP_ABS_A:       r = row(2'h3, 4'h8, EX_ST_A, AS_ABS);
			OP_PSW_IMM:     r = row(2'h3, 4'h6, EX_PSW_IMM, AS_NONE);
			OP_A_PSW:       r = row(2'h2, 4'h4, EX_A_PSW, AS_NONE);
			OP_PSW_A:       r = row(2'h2, 4'h4, EX_PSW_A, AS_NONE);
			OP_A_DE:        r = row(2'h1, 4'h6, EX_LD_A, AS_DE);
			OP_DE_A:        r = row(2'h1, 4'h6, EX_ST_A, AS_DE);
			OP_A_PTR:       r = row(2'h1, 4'h6, EX_LD_A, AS_PTR);
			OP_PTR_A:       r = row(2'h1, 4'h6, EX_ST_A, AS_PTR);
			OP_A_PTR_OFS:   r = row(2'h2, 4'h6, EX_LD_A, AS_PTR_OFS);
			OP_PTR_OFS_A:   r = row(2'h2, 4'h6, EX_ST_A, AS_PTR_OFS);
			OP_XCH_A_X:     r = row(2'h1, 4'h4, EX_XCH_R, AS_NONE);
			OP_XCH_A_R:     r = row(2'h2, 4'h6, EX_XCH_R, AS_NONE);
			OP_XCH_SHORT:   r = row(2'h2, 4'h6, EX_XCH_MEM, AS_SHORT);
			OP_XCH_SFR:     r = row(2'h2, 4'h6, EX_XCH_MEM, AS_SFR);
			OP_XCH_DE:      r = row(2'h1, 4'h8, EX_XCH_MEM, AS_DE);
			OP_XCH_PTR:     r = row(2'h1, 4'h8, EX_XCH_MEM, AS_PTR);
			OP_XCH_PTR_OFS: r = row(2'h2, 4'h8, EX_XCH_MEM, AS_PTR_OFS);
			default:        r = row(2'h1, 4'h4, EX_ILLEGAL, AS_NONE);
		endcase
	end

	// unpack the row onto the link
	assign dif.len    = r[12:11];
	assign dif.clocks = r[10:7];
	assign dif.ex     = exec_e'(r[6:3]);
	assign dif.asrc   = asrc_e'(r[2:0]);

endmodule

// *** xfer_exec.sv ***
// byte transfer and exchange executor
// Function
// - byte registers numbered X A C B E D L H
// - pairs numbered word_acc BC DE pointer three
// - short-direct operand maps into FE20H..FF1FH
// - short-direct pair operand must be even
// - absolute address spans all; word needs even
// - call-table address even, 0040H to 007FH
// - bit 3 bits, byte 8, word 16
// - branch displacement is signed 8-bit
// - A accumulator, A with X word accumulator
// - load A from pointer plus offset, 6 clocks
// - store A there, 6 clocks, flags kept
// - atomic swap A with pointer plus offset
// - status word loads update Z, AC, CY
`timescale 1ns/1ns
module xfer_exec
	import xfer_pkg::*;
(
	// clock, reset, enable
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        ce_in,
	// program memory, combinational read
	output wire logic [15:0] prog_addr_out,
	input  wire logic [7:0]  prog_data_in,
	// data memory and special registers, combinational read
	output wire logic [15:0] mem_addr_out,
	output wire logic [7:0]  mem_wdata_out,
	output wire logic        mem_we_out,
	output wire logic        mem_re_out,
	input  wire logic [7:0]  mem_rdata_in,
	// execution status
	output wire logic        retire_out,
	output wire logic        illegal_out,
	output wire logic [7:0]  psw_out,
	output wire logic [15:0] word_acc_out,
	// operand checker
	input  wire logic [2:0]  chk_kind_in,
	input  wire logic [15:0] chk_value_in,
	input  wire logic [7:0]  chk_disp_in,
	output wire logic        chk_ok_out,
	output wire logic [2:0]  chk_bit_out,
	output wire logic [15:0] chk_offset_out
);

	// sequencer states
	typedef enum logic [2:0] {
		ST_OPCODE  = 3'h0,
		ST_OPERAND = 3'h1,
		ST_ISSUE   = 3'h2,
		ST_ACCESS  = 3'h3,
		ST_WAIT    = 3'h4
	} state_e;

	core_if cif (); // link to decoder and register file

	// sequencer state
	state_e      state_r, state_nxt;     // current phase
	logic [3:0]  cnt_r, cnt_nxt;         // clock index inside instruction
	logic [15:0] pc_r, pc_nxt;           // fetch address
	logic [7:0]  op_r, op_nxt;           // latched opcode
	logic [7:0]  b1_r, b1_nxt;           // first operand byte
	logic [7:0]  b2_r, b2_nxt;           // second operand byte
	logic [7:0]  psw_r, psw_nxt;         // status word

	// memory port state, all driven from flops
	logic [15:0] maddr_r, maddr_nxt;     // access address
	logic [7:0]  mwdata_r, mwdata_nxt;   // write data
	logic        mwe_r, mwe_nxt;         // write strobe
	logic        mre_r, mre_nxt;         // read strobe

	// operand checker state
	logic        chk_ok_r, chk_ok_nxt;   // address legal
	logic [2:0]  chk_bit_r, chk_bit_nxt; // bit number field
	logic [15:0] chk_ofs_r, chk_ofs_nxt; // sign-extended displacement

	// combinational helpers
	logic        last;                   // this clock ends the instruction
	logic        bad_sel;                // register operand not allowed
	logic [2:0]  sel;                    // byte register operand
	logic [15:0] ea;                     // effective address

	// decoder and register file
	xfer_decode u_dec (
		.dif (cif.dec)
	);

	xfer_regs u_regs (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.ce_in  (ce_in),
		.rif    (cif.rf)
	);

	// decode the byte on the fetch bus in the opcode clock, the latched one after
	assign cif.opcode = (state_r == ST_OPCODE) ? prog_data_in : op_r;

	// register operand: exchange with X names it in the opcode
	assign sel = (op_r == OP_XCH_A_X) ? REG_X : b1_r[2:0];
	assign cif.rd_sel = sel;

	// A is not a register operand of the A,r and r,A moves; exchange also excludes X
	always_comb
	begin
		case (cif.ex)
			EX_A_R, EX_R_A: bad_sel = (sel == REG_A);
			EX_XCH_R:       bad_sel = (op_r == OP_XCH_A_R) && ((sel == REG_A) || (sel == REG_X));
			default:        bad_sel = 1'b0;
		endcase
	end

	// pointer pair for indirect forms
	assign cif.pair_sel = (cif.asrc == AS_DE) ? PAIR_DE : PAIR_PTR3;

	// effective address by source
	always_comb
	begin
		case (cif.asrc)
			AS_SHORT:   ea = SHORT_FIRST + {8'h00, b1_r};
			AS_SFR:     ea = SFR_BASE + {8'h00, b1_r};
			AS_ABS:     ea = {b2_r, b1_r};
			AS_DE:      ea = cif.pair_data;
			AS_PTR:     ea = cif.pair_data;
			AS_PTR_OFS: ea = cif.pair_data + {8'h00, b1_r};
			default:    ea = 16'h0000;
		endcase
	end

	// the instruction occupies exactly its documented clock count
	assign last = ((state_r == ST_ACCESS) || (state_r == ST_WAIT)) && (cnt_r == cif.clocks - 4'h1);

	// sequencer next state
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r + 4'h1;
		pc_nxt    = pc_r;
		op_nxt    = op_r;
		b1_nxt    = b1_r;
		b2_nxt    = b2_r;
		case (state_r)
			// opcode clock: latch and advance
			ST_OPCODE:
			begin
				op_nxt    = prog_data_in;
				pc_nxt    = pc_r + 16'h0001;
				state_nxt = (cif.len == 2'h1) ? ST_ISSUE : ST_OPERAND;
			end
			// operand clocks: low byte first, so a word is {b2, b1}
			ST_OPERAND:
			begin
				if (cnt_r == 4'h1)
					b1_nxt = prog_data_in;
				else
					b2_nxt = prog_data_in;
				pc_nxt = pc_r + 16'h0001;
				if (cnt_r == {2'h0, cif.len} - 4'h1)
					state_nxt = ST_ISSUE;
			end
			// address goes out on the memory flops
			ST_ISSUE:
				state_nxt = ST_ACCESS;
			// memory is live and results commit in ST_ACCESS; ST_WAIT clocks only count
			ST_ACCESS, ST_WAIT:
			begin
				if (last)
				begin
					state_nxt = ST_OPCODE;
					cnt_nxt   = 4'h0;
				end
				else
					state_nxt = ST_WAIT;
			end
			default:
			begin
				state_nxt = ST_OPCODE;
				cnt_nxt   = 4'h0;
			end
		endcase
	end

	// memory port next values; strobes last exactly the access clock
	always_comb
	begin
		maddr_nxt  = maddr_r;
		mwdata_nxt = mwdata_r;
		mwe_nxt    = 1'b0;
		mre_nxt    = 1'b0;
		if (state_r == ST_ISSUE)
		begin
			maddr_nxt = ea;
			case (cif.ex)
				// immediate into short window or special register
				EX_MEM_IMM:
				begin
					mwdata_nxt = b2_r;
					mwe_nxt    = 1'b1;
				end
				// store of A
				EX_ST_A:
				begin
					mwdata_nxt = cif.a_data;
					mwe_nxt    = 1'b1;
				end
				// load into A
				EX_LD_A:
					mre_nxt = 1'b1;
				// read and write in the same clock: old byte is read, A lands at the edge,
				// so nothing can slip between the two halves of the swap
				EX_XCH_MEM:
				begin
					mwdata_nxt = cif.a_data;
					mwe_nxt    = 1'b1;
					mre_nxt    = 1'b1;
				end
				default:
				begin
					mwe_nxt = 1'b0;
					mre_nxt = 1'b0;
				end
			endcase
		end
	end

	// register and status commits in the access clock
	always_comb
	begin
		cif.wr_en     = 1'b0;
		cif.wr_sel    = sel;
		cif.wr_data   = 8'h00;
		cif.a_wr_en   = 1'b0;
		cif.a_wr_data = 8'h00;
		psw_nxt       = psw_r;
		if ((state_r == ST_ACCESS) && !bad_sel)
		begin
			case (cif.ex)
				// immediate into a byte register
				EX_R_IMM:
				begin
					cif.wr_en   = 1'b1;
					cif.wr_data = b2_r;
				end
				// register to A
				EX_A_R:
				begin
					cif.a_wr_en   = 1'b1;
					cif.a_wr_data = cif.rd_data;
				end
				// A to register
				EX_R_A:
				begin
					cif.wr_en   = 1'b1;
					cif.wr_data = cif.a_data;
				end
				// register swap, both ports in one edge
				EX_XCH_R:
				begin
					cif.wr_en     = 1'b1;
					cif.wr_data   = cif.a_data;
					cif.a_wr_en   = 1'b1;
					cif.a_wr_data = cif.rd_data;
				end
				// memory byte into A
				EX_LD_A, EX_XCH_MEM:
				begin
					cif.a_wr_en   = 1'b1;
					cif.a_wr_data = mem_rdata_in;
				end
				// status word loads take Z, AC and CY from the byte written
				EX_PSW_IMM:
					psw_nxt = b2_r;
				EX_PSW_A:
					psw_nxt = cif.a_data;
				// status word read leaves it alone
				EX_A_PSW:
				begin
					cif.a_wr_en   = 1'b1;
					cif.a_wr_data = psw_r;
				end
				// all other moves keep the flags
				default:
					psw_nxt = psw_r;
			endcase
		end
	end

	// operand checker, one clock of latency
	always_comb
	begin
		chk_ok_nxt  = addr_legal(chk_kind_in, chk_value_in);
		chk_bit_nxt = chk_value_in[2:0];
		chk_ofs_nxt = {{8{chk_disp_in[7]}}, chk_disp_in};
	end

	// register every group; nothing moves while the enable is low
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_r   <= ST_OPCODE;
			cnt_r     <= 4'h0;
			pc_r      <= PC_RESET;
			op_r      <= 8'h00;
			b1_r      <= 8'h00;
			b2_r      <= 8'h00;
			psw_r     <= PSW_RESET;
			maddr_r   <= 16'h0000;
			mwdata_r  <= 8'h00;
			mwe_r     <= 1'b0;
			mre_r     <= 1'b0;
			chk_ok_r  <= 1'b0;
			chk_bit_r <= 3'h0;
			chk_ofs_r <= 16'h0000;
		end
		else if (ce_in)
		begin
			state_r   <= state_nxt;
			cnt_r     <= cnt_nxt;
			pc_r      <= pc_nxt;
			op_r      <= op_nxt;
			b1_r      <= b1_nxt;
			b2_r      <= b2_nxt;
			psw_r     <= psw_nxt;
			maddr_r   <= maddr_nxt;
			mwdata_r  <= mwdata_nxt;
			mwe_r     <= mwe_nxt;
			mre_r     <= mre_nxt;
			chk_ok_r  <= chk_ok_nxt;
			chk_bit_r <= chk_bit_nxt;
			chk_ofs_r <= chk_ofs_nxt;
		end
	end

	// outputs; strobes are gated by the enable so a frozen core writes nothing twice
	assign prog_addr_out  = pc_r;
	assign mem_addr_out   = maddr_r;
	assign mem_wdata_out  = mwdata_r;
	assign mem_we_out     = mwe_r & ce_in;
	assign mem_re_out     = mre_r & ce_in;
	assign retire_out     = last & ce_in;
	assign illegal_out    = (state_r == ST_ACCESS) && ce_in && ((cif.ex == EX_ILLEGAL) || bad_sel);
	assign psw_out        = psw_r;
	assign word_acc_out   = cif.wacc_data;
	assign chk_ok_out     = chk_ok_r;
	assign chk_bit_out    = chk_bit_r;
	assign chk_offset_out = chk_ofs_r;

endmodule

// *** xfer_exec_asserts.sv ***
// concurrent checks on the executor ports
`timescale 1ns/1ns
module xfer_exec_asserts (
	// clock and reset
	input wire logic        clk_in,
	input wire logic        rst_in,
	// data memory
	input wire logic [7:0]  mem_wdata_out,
	input wire logic        mem_we_out,
	input wire logic        mem_re_out,
	input wire logic [7:0]  mem_rdata_in,
	// status
	input wire logic        retire_out,
	input wire logic [7:0]  psw_out,
	input wire logic [15:0] word_acc_out,
	// operand checker
	input wire logic [2:0]  chk_kind_in,
	input wire logic [15:0] chk_value_in,
	input wire logic [7:0]  chk_disp_in,
	input wire logic        chk_ok_out,
	input wire logic [2:0]  chk_bit_out,
	input wire logic [15:0] chk_offset_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	// no instruction is shorter than four clocks
	sequence quiet_three;
		!retire_out [*3];
	endsequence
	// one access clock that both reads and writes memory
	sequence swap_access;
		mem_re_out && mem_we_out;
	endsequence

	AST_RETIRE_GAP: assert property (retire_out |=> quiet_three)
		else $error("retire too soon");
	AST_READ_PULSE: assert property (mem_re_out |=> !mem_re_out)
		else $error("read strobe longer than one clock");
	AST_LOAD_A: assert property (mem_re_out && !mem_we_out |=>
		word_acc_out[15:8] == $past(mem_rdata_in) && $stable(word_acc_out[7:0])) else $error("load missed A");
	AST_STORE_FLAGS: assert property (mem_we_out && !mem_re_out |=> $stable(psw_out))
		else $error("store touched flags");
	AST_SWAP_A: assert property (swap_access |=> word_acc_out[15:8] == $past(mem_rdata_in))
		else $error("swap lost memory byte");
	AST_SWAP_WDATA: assert property (swap_access |-> mem_wdata_out == word_acc_out[15:8])
		else $error("swap wrote wrong byte");
	AST_CHK_SHORT: assert property (chk_kind_in == 3'h0 |=> chk_ok_out ==
		($past(chk_value_in) inside {[16'hFE20:16'hFF1F]})) else $error("short window");
	AST_CHK_PAIR: assert property (chk_kind_in == 3'h1 |=> chk_ok_out ==
		($past(chk_value_in) inside {[16'hFE20:16'hFF1F]} && !$past(chk_value_in[0])))
		else $error("short pair alignment");
	AST_CHK_ABS: assert property (chk_kind_in == 3'h3 |=> chk_ok_out == !$past(chk_value_in[0]))
		else $error("absolute word alignment");
	AST_CHK_CALLT: assert property (chk_kind_in == 3'h4 |=> chk_ok_out ==
		($past(chk_value_in) inside {[16'h0040:16'h007F]} && !$past(chk_value_in[0])))
		else $error("call table range");
	AST_CHK_BIT: assert property (##1 chk_bit_out == $past(chk_value_in[2:0]))
		else $error("bit number width");
	AST_CHK_DISP: assert property (##1 chk_offset_out == {{8{$past(chk_disp_in[7])}}, $past(chk_disp_in)})
		else $error("displacement sign");
endmodule

bind xfer_exec xfer_exec_asserts i_chk (.*);

// *** xfer_mem_model.sv ***
// behavioural program and data memory facing the executor
`timescale 1ns/1ns
module xfer_mem_model (
	// clock
	input  wire logic        clk_in,
	// program side, combinational read
	input  wire logic [15:0] prog_addr_in,
	output logic      [7:0]  prog_data_out,
	// data side, read before write
	input  wire logic [15:0] mem_addr_in,
	input  wire logic [7:0]  mem_wdata_in,
	input  wire logic        mem_we_in,
	input  wire logic        mem_re_in,
	output logic      [7:0]  mem_rdata_out
);
	logic [7:0] prog [0:65535]; // program bytes, filled by the bench
	logic [7:0] data [0:65535]; // data ram and special registers
	logic [7:0] last_r = 8'h00; // last byte handed out

	// an idle read bus shows the inverse of its last byte, never a stale match
	assign prog_data_out = prog[prog_addr_in];
	assign mem_rdata_out = mem_re_in ? data[mem_addr_in] : ~last_r;

	// writes land at the edge that ends the strobe cycle
	always @(posedge clk_in)
	begin
		if (mem_we_in)
			data[mem_addr_in] <= mem_wdata_in;
		if (mem_re_in)
			last_r <= data[mem_addr_in];
	end
endmodule

// *** xfer_pkg.sv ***
// shared constants, types and helpers for the byte transfer executor
package xfer_pkg;

	// byte register numbers, order X A C B E D L H
	localparam logic [2:0] REG_X = 3'h0;
	localparam logic [2:0] REG_A = 3'h1;
	localparam logic [2:0] REG_C = 3'h2;
	localparam logic [2:0] REG_B = 3'h3;
	localparam logic [2:0] REG_E = 3'h4;
	localparam logic [2:0] REG_D = 3'h5;
	localparam logic [2:0] REG_L = 3'h6;
	localparam logic [2:0] REG_H = 3'h7;

	// register pair numbers; pair n is {reg 2n+1, reg 2n}
	localparam logic [1:0] PAIR_WORD_ACC = 2'h0;
	localparam logic [1:0] PAIR_BC       = 2'h1;
	localparam logic [1:0] PAIR_DE       = 2'h2;
	localparam logic [1:0] PAIR_PTR3     = 2'h3;

	// address windows
	localparam logic [15:0] SHORT_FIRST  = 16'hFE20;
	localparam logic [15:0] SHORT_LAST   = 16'hFF1F;
	localparam logic [15:0] SFR_BASE     = 16'hFF00;
	localparam logic [15:0] CALLT_FIRST  = 16'h0040;
	localparam logic [15:0] CALLT_LAST   = 16'h007F;

	// status word layout and reset value
	localparam int         PSW_CY_BIT = 0;
	localparam int         PSW_AC_BIT = 4;
	localparam int         PSW_Z_BIT  = 6;
	localparam logic [7:0] PSW_RESET  = 8'h00;
	localparam logic [7:0] PC_RESET_LO = 8'h00;
	localparam logic [15:0] PC_RESET  = {8'h00, PC_RESET_LO};

	// opcodes of the executor
	localparam logic [7:0] OP_R_IMM      = 8'h10;
	localparam logic [7:0] OP_SHORT_IMM  = 8'h11;
	localparam logic [7:0] OP_SFR_IMM    = 8'h12;
	localparam logic [7:0] OP_A_R        = 8'h13;
	localparam logic [7:0] OP_R_A        = 8'h14;
	localparam logic [7:0] OP_A_SHORT    = 8'h15;
	localparam logic [7:0] OP_SHORT_A    = 8'h16;
	localparam logic [7:0] OP_A_SFR      = 8'h17;
	localparam logic [7:0] OP_SFR_A      = 8'h18;
	localparam logic [7:0] OP_A_ABS      = 8'h19;
	localparam logic [7:0] OP_ABS_A      = 8'h1A;
	localparam logic [7:0] OP_PSW_IMM    = 8'h1B;
	localparam logic [7:0] OP_A_PSW      = 8'h1C;
	localparam logic [7:0] OP_PSW_A      = 8'h1D;
	localparam logic [7:0] OP_A_DE       = 8'h1E;
	localparam logic [7:0] OP_DE_A       = 8'h1F;
	localparam logic [7:0] OP_A_PTR      = 8'h20;
	localparam logic [7:0] OP_PTR_A      = 8'h21;
	localparam logic [7:0] OP_A_PTR_OFS  = 8'h22;
	localparam logic [7:0] OP_PTR_OFS_A  = 8'h23;
	localparam logic [7:0] OP_XCH_A_X    = 8'h24;
	localparam logic [7:0] OP_XCH_A_R    = 8'h25;
	localparam logic [7:0] OP_XCH_SHORT  = 8'h26;
	localparam logic [7:0] OP_XCH_SFR    = 8'h27;
	localparam logic [7:0] OP_XCH_DE     = 8'h28;
	localparam logic [7:0] OP_XCH_PTR    = 8'h29;
	localparam logic [7:0] OP_XCH_PTR_OFS = 8'h2A;

	// operand check kinds
	localparam logic [2:0] CHK_SHORT      = 3'h0;
	localparam logic [2:0] CHK_SHORT_PAIR = 3'h1;
	localparam logic [2:0] CHK_ABS_BYTE   = 3'h2;
	localparam logic [2:0] CHK_ABS_WORD   = 3'h3;
	localparam logic [2:0] CHK_CALLT      = 3'h4;

	// execution class of a decoded instruction
	typedef enum logic [3:0] {
		EX_ILLEGAL = 4'h0, EX_R_IMM = 4'h1, EX_MEM_IMM = 4'h2, EX_A_R = 4'h3,
		EX_R_A = 4'h4, EX_LD_A = 4'h5, EX_ST_A = 4'h6, EX_XCH_R = 4'h7,
		EX_XCH_MEM = 4'h8, EX_PSW_IMM = 4'h9, EX_A_PSW = 4'hA, EX_PSW_A = 4'hB
	} exec_e;

	// where the memory address comes from
	typedef enum logic [2:0] {
		AS_NONE = 3'h0, AS_SHORT = 3'h1, AS_SFR = 3'h2, AS_ABS = 3'h3,
		AS_DE = 3'h4, AS_PTR = 3'h5, AS_PTR_OFS = 3'h6
	} asrc_e;

	// true when an address lies in the short-direct window
	function automatic logic in_short(input logic [15:0] a);
		in_short = (a >= SHORT_FIRST) && (a <= SHORT_LAST);
	endfunction

	// legality of an address operand of the given kind
	function automatic logic addr_legal(input logic [2:0] kind, input logic [15:0] a);
		case (kind)
			CHK_SHORT:      addr_legal = in_short(a);
			CHK_SHORT_PAIR: addr_legal = in_short(a) && !a[0];
			CHK_ABS_BYTE:   addr_legal = 1'b1;
			CHK_ABS_WORD:   addr_legal = !a[0];
			CHK_CALLT:      addr_legal = (a >= CALLT_FIRST) && (a <= CALLT_LAST) && !a[0];
			default:        addr_legal = 1'b0;
		endcase
	endfunction

endpackage

// *** xfer_regs.sv ***
// eight byte registers with byte and pair views
`timescale 1ns/1ns
module xfer_regs
	import xfer_pkg::*;
(
	// clock and reset
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic ce_in,
	// register link
	core_if.rf        rif
);

	logic [7:0] regs_r   [8]; // byte registers by absolute number
	logic [7:0] regs_nxt [8]; // next register values

	// a pair is the odd register above the even one
	function automatic logic [15:0] pair_of(input logic [1:0] p, input logic [7:0] v [8]);
		pair_of = {v[{p, 1'b1}], v[{p, 1'b0}]};
	endfunction

	// read views
	assign rif.rd_data   = regs_r[rif.rd_sel];
	assign rif.a_data    = regs_r[REG_A];
	assign rif.pair_data = pair_of(rif.pair_sel, regs_r);
	assign rif.wacc_data = pair_of(PAIR_WORD_ACC, regs_r);

	// next values; the executor never writes A through both ports at once
	always_comb
	begin
		for (int i = 0; i < 8; i++)
			regs_nxt[i] = regs_r[i];
		if (rif.wr_en)
			regs_nxt[rif.wr_sel] = rif.wr_data;
		if (rif.a_wr_en)
			regs_nxt[REG_A] = rif.a_wr_data;
	end

	// register the file; held while the clock enable is low
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			for (int i = 0; i < 8; i++)
				regs_r[i] <= 8'h00;
		else if (ce_in)
			regs_r <= regs_nxt;
	end

endmodule
